// [rtl/touch_detector_map.vh]
// register offsets, field positions, reset values and timing counts
// assumes a 40 MHz pclk; included by the detector design
`ifndef TOUCH_DETECTOR_MAP_VH
`define TOUCH_DETECTOR_MAP_VH
// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_BANK0        12'h000
`define OFS_BANK1        12'h004
`define OFS_BANK2        12'h008
`define OFS_COUNT        12'h00C
`define OFS_STATUS       12'h010
`define OFS_AVERAGE      12'h014
// ************************************************************
// reset values
// ************************************************************
`define RST_BANK0        8'h00
`define RST_BANK1        8'h00
`define RST_BANK2        8'h00
// ************************************************************
// field positions
// ************************************************************
`define B0_TOUCH_HI      7
`define B0_TOUCH_LO      5
`define B0_PROX_HI       4
`define B0_PROX_LO       3
`define B0_POLARITY      1
`define B0_EXT_SEL       0
`define B1_STREAM        7
`define B1_INTV_HI       6
`define B1_INTV_LO       5
`define B1_HALT_HI       4
`define B1_HALT_LO       3
`define B1_CTRL_DIR      0
`define B2_OUT_EVENT     5
`define B2_RELEASE       4
`define B2_TUNE_HI       3
`define B2_TUNE_LO       1
// ************************************************************
// timing in source units and derived counts at 40 MHz
// ************************************************************
`define CLK_HZ           40000000
`define INTV0_US         9010
`define INTV1_US         27000
`define INTV2_US         100000
`define INTV3_US         300000
`define HALT_S_1         18
`define HALT_S_2         60
`define HALT_S_3         3
`define PULSE_MIN_MS     25
`define PULSE_MAX_MS     35
`define EXT_HALT_MS      50
`define PROX_CONSEC      6
`define TOUCH_CONSEC     2
// least times round up, longest times round down
`define INTV0_CYC  ((`INTV0_US * (`CLK_HZ / 1000000)))
`define INTV1_CYC  ((`INTV1_US * (`CLK_HZ / 1000000)))
`define INTV2_CYC  ((`INTV2_US * (`CLK_HZ / 1000000)))
`define INTV3_CYC  ((`INTV3_US * (`CLK_HZ / 1000000)))
`define PULSE_MIN_CYC    ((`PULSE_MIN_MS * (`CLK_HZ / 1000)) + 1)
`define PULSE_MAX_CYC    ((`PULSE_MAX_MS * (`CLK_HZ / 1000)) - 1)
`define EXT_HALT_CYC     (`EXT_HALT_MS * (`CLK_HZ / 1000))
`endif

// [rtl/touch_detector.v]
// single-channel proximity/touch detection logic with option banks on apb
// assumes a charge-transfer front end that reports pulses and a trip
`timescale 1ns/10ps
`include "touch_detector_map.vh"

module touch_detector #(
  parameter        CNT_W         = 12,
  parameter [31:0] INTV0_CYC     = `INTV0_CYC,
  parameter [31:0] INTV1_CYC     = `INTV1_CYC,
  parameter [31:0] INTV2_CYC     = `INTV2_CYC,
  parameter [31:0] INTV3_CYC     = `INTV3_CYC,
  parameter [31:0] SEC_CYC       = `CLK_HZ,
  parameter [31:0] PULSE_MIN_CYC = `PULSE_MIN_CYC,
  parameter [31:0] PULSE_MAX_CYC = `PULSE_MAX_CYC,
  parameter [31:0] EXT_HALT_CYC  = `EXT_HALT_CYC
) (
  // clock, reset, enable
  input  wire             pclk,
  input  wire             presetn,
  input  wire             clk_en,
  // apb slave
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output reg              pready,
  output reg              pslverr,
  // front end
  input  wire             xfer_pulse,
  input  wire             ref_trip,
  output reg              charge_run,
  output reg  [9:0]       tuning_target,
  output reg              tuning_start,
  output reg              stream_enable,
  // pins
  output reg              detect_out,
  output reg              detect_oe,
  input  wire             ctrl_in,
  output reg              ctrl_out,
  output reg              ctrl_oe
);

  // ************************************************************
  // states
  // ************************************************************
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_PROX  = 2'h1;
  localparam [1:0] ST_TOUCH = 2'h2;

  reg [7:0]       bank0_ff, bank1_ff, bank2_ff;
  reg [CNT_W-1:0] pulse_cnt_ff, count_ff, avg_ff, frozen_ff;
  reg [31:0]      period_ff, halt_ff, ctrl_len_ff;
  reg [1:0]       state_ff;
  reg [2:0]       prox_run_ff, touch_run_ff, rel_run_ff;
  reg             sync1_ff, sync2_ff, ctrl_prev_ff;
  reg             measuring_ff, standby_ff, seeded_ff;
  reg             new_count_ff;

  // ************************************************************
  // option decode
  // ************************************************************
  reg [9:0]       touch_dec;
  reg [5:0]       prox_dec;
  reg [CNT_W-1:0] rel_thr;
  reg [31:0]      interval, halt_limit;
  reg [9:0]       tune_base;
  // decoded at their own width, widened to the count width
  wire [CNT_W-1:0] touch_thr = {{(CNT_W-10){1'b0}}, touch_dec};
  wire [CNT_W-1:0] prox_thr  = {{(CNT_W-6){1'b0}}, prox_dec};
  always @* begin
    case (bank0_ff[`B0_TOUCH_HI:`B0_TOUCH_LO])
      3'h0:    touch_dec = 10'h028;
      3'h1:    touch_dec = 10'h03C;
      3'h2:    touch_dec = 10'h064;
      3'h3:    touch_dec = 10'h0C8;
      3'h4:    touch_dec = 10'h168;
      3'h5:    touch_dec = 10'h1F4;
      3'h6:    touch_dec = 10'h2BC;
      default: touch_dec = 10'h384;
    endcase
    case (bank0_ff[`B0_PROX_HI:`B0_PROX_LO])
      2'h0:    prox_dec = 6'h04;
      2'h1:    prox_dec = 6'h08;
      2'h2:    prox_dec = 6'h10;
      default: prox_dec = 6'h20;
    endcase
    if (bank2_ff[`B2_RELEASE])
      rel_thr = touch_thr - (touch_thr >> 3);
    else
      rel_thr = touch_thr - (touch_thr >> 2);
    case (bank1_ff[`B1_INTV_HI:`B1_INTV_LO])
      2'h0:    interval = INTV0_CYC;
      2'h1:    interval = INTV1_CYC;
      2'h2:    interval = INTV2_CYC;
      default: interval = INTV3_CYC;
    endcase
    // halt limit in pclk cycles; zero means forever
    case (bank1_ff[`B1_HALT_HI:`B1_HALT_LO])
      2'h0:    halt_limit = 32'h0;
      2'h1:    halt_limit = `HALT_S_1 * SEC_CYC;
      2'h2:    halt_limit = `HALT_S_2 * SEC_CYC;
      default: halt_limit = `HALT_S_3 * SEC_CYC;
    endcase
    case (bank2_ff[`B2_TUNE_HI:`B2_TUNE_LO])
      3'h0:    tune_base = 10'd200;
      3'h1:    tune_base = 10'd250;
      3'h2:    tune_base = 10'd300;
      3'h3:    tune_base = 10'd350;
      3'h4:    tune_base = 10'd400;
      3'h5:    tune_base = 10'd550;
      3'h6:    tune_base = 10'd700;
      default: tune_base = 10'd850;
    endcase
  end

  // ************************************************************
  // control pin measurement
  // ************************************************************
  wire ctrl_is_in  = ~bank1_ff[`B1_CTRL_DIR];
  wire ext_high    = ctrl_is_in & sync2_ff & (ctrl_len_ff > EXT_HALT_CYC);
  wire charge_halt = ext_high & ~bank0_ff[`B0_EXT_SEL];
  wire filter_halt = ext_high & bank0_ff[`B0_EXT_SEL];
  // pulse window on the falling edge
  wire valid_pulse = ctrl_is_in & ctrl_prev_ff & ~sync2_ff &
                     (ctrl_len_ff >= PULSE_MIN_CYC) & (ctrl_len_ff <= PULSE_MAX_CYC);

  // ************************************************************
  // divergence
  // ************************************************************
  wire below_prox  = (avg_ff > count_ff) && ((avg_ff - count_ff) > prox_thr);
  wire below_touch = (avg_ff > count_ff) && ((avg_ff - count_ff) > touch_thr);
  wire above_rel   = (count_ff > avg_ff) && ((count_ff - avg_ff) >= rel_thr);
  wire halt_fault  = (halt_limit != 32'h0) && (halt_ff >= halt_limit) && !filter_halt;

  // ************************************************************
  // apb
  // ************************************************************
  wire acc  = psel & penable & ~pready;
  // write lands at the edge that completes the access
  wire wr   = psel & penable & pready & pwrite;
  reg  [31:0] rd_mux;
  reg         rd_err;
  always @* begin
    rd_err = 1'b0;
    case (paddr)
      `OFS_BANK0:   rd_mux = {24'h0, bank0_ff};
      `OFS_BANK1:   rd_mux = {24'h0, bank1_ff};
      `OFS_BANK2:   rd_mux = {24'h0, bank2_ff};
      `OFS_COUNT:   rd_mux = {{(32-CNT_W){1'b0}}, count_ff};
      `OFS_STATUS:  rd_mux = {26'h0, seeded_ff, standby_ff, ctrl_is_in, measuring_ff,
                              state_ff};
      `OFS_AVERAGE: rd_mux = {{(32-CNT_W){1'b0}}, avg_ff};
      default: begin
        rd_mux = 32'h0;
        rd_err = 1'b1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank0_ff <= `RST_BANK0;
      bank1_ff <= `RST_BANK1;
      bank2_ff <= `RST_BANK2;
      prdata   <= 32'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else if (clk_en) begin
      pready  <= acc;
      pslverr <= acc & rd_err;
      if (acc && !pwrite)
        prdata <= rd_mux;
      if (wr && paddr == `OFS_BANK0)
        bank0_ff <= pwdata[7:0] & 8'hFB;
      if (wr && paddr == `OFS_BANK1)
        bank1_ff <= pwdata[7:0] & 8'hF9;
      if (wr && paddr == `OFS_BANK2)
        bank2_ff <= pwdata[7:0] & 8'h3E;
    end
  end

  // ************************************************************
  // measurement, filter and detection
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff      <= 1'b0;
      sync2_ff      <= 1'b0;
      ctrl_prev_ff  <= 1'b0;
      ctrl_len_ff   <= 32'h0;
      period_ff     <= 32'h0;
      halt_ff       <= 32'h0;
      pulse_cnt_ff  <= {CNT_W{1'b0}};
      count_ff      <= {CNT_W{1'b0}};
      avg_ff        <= {CNT_W{1'b0}};
      frozen_ff     <= {CNT_W{1'b0}};
      state_ff      <= ST_IDLE;
      prox_run_ff   <= 3'h0;
      touch_run_ff  <= 3'h0;
      rel_run_ff    <= 3'h0;
      measuring_ff  <= 1'b0;
      standby_ff    <= 1'b0;
      seeded_ff     <= 1'b0;
      new_count_ff  <= 1'b0;
      charge_run    <= 1'b0;
      tuning_start  <= 1'b0;
      tuning_target <= 10'h0;
      stream_enable <= 1'b0;
    end else if (clk_en) begin
      sync1_ff      <= ctrl_in;
      sync2_ff      <= sync1_ff;
      ctrl_prev_ff  <= sync2_ff;
      tuning_target <= tune_base;
      stream_enable <= bank1_ff[`B1_STREAM];
      if (!sync2_ff)
        ctrl_len_ff <= 32'h0;
      else if (ctrl_len_ff != 32'hFFFFFFFF)
        ctrl_len_ff <= ctrl_len_ff + 32'h1;
      tuning_start <= valid_pulse;
      new_count_ff <= 1'b0;
      if (period_ff >= interval - 32'h1)
        period_ff <= 32'h0;
      else
        period_ff <= period_ff + 32'h1;
      // stop only between cycles, reseed on release
      if (!measuring_ff && charge_halt)
        standby_ff <= 1'b1;
      else if (standby_ff && !charge_halt) begin
        standby_ff <= 1'b0;
        seeded_ff  <= 1'b0;
      end
      if (period_ff == 32'h0 && !measuring_ff && !standby_ff && !charge_halt) begin
        measuring_ff <= 1'b1;
        charge_run   <= 1'b1;
        pulse_cnt_ff <= {CNT_W{1'b0}};
      end else if (measuring_ff) begin
        if (ref_trip) begin
          measuring_ff <= 1'b0;
          charge_run   <= 1'b0;
          count_ff     <= pulse_cnt_ff;
          new_count_ff <= 1'b1;
        end else if (xfer_pulse)
          pulse_cnt_ff <= pulse_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (state_ff == ST_PROX && !filter_halt)
        halt_ff <= halt_ff + 32'h1;
      else if (state_ff != ST_PROX)
        halt_ff <= 32'h0;
      if (halt_fault || valid_pulse) begin
        state_ff     <= ST_IDLE;
        seeded_ff    <= 1'b0;
        prox_run_ff  <= 3'h0;
        touch_run_ff <= 3'h0;
      end else if (new_count_ff) begin
        if (!seeded_ff) begin
          avg_ff    <= count_ff;
          seeded_ff <= 1'b1;
        end else begin
          touch_run_ff <= below_touch ? ((touch_run_ff == 3'h7) ? 3'h7 : touch_run_ff + 3'h1)
                                      : 3'h0;
          prox_run_ff  <= below_prox ? ((prox_run_ff == 3'h7) ? 3'h7 : prox_run_ff + 3'h1)
                                     : 3'h0;
          case (state_ff)
            ST_IDLE: begin
              if (below_prox && prox_run_ff >= `PROX_CONSEC - 1) begin
                state_ff  <= ST_PROX;
                frozen_ff <= avg_ff;
              end else if (!filter_halt)
                avg_ff <= avg_ff - (avg_ff >> 4) + (count_ff >> 4);
            end
            ST_PROX: begin
              if (below_touch && touch_run_ff >= `TOUCH_CONSEC - 1) begin
                avg_ff   <= frozen_ff - touch_thr;
                state_ff <= ST_TOUCH;
              end else if (!below_prox)
                state_ff <= ST_IDLE;
            end
            ST_TOUCH: begin
              // release when above by release threshold
              if (above_rel)
                state_ff <= ST_IDLE;
              else if (!filter_halt)
                avg_ff <= avg_ff - (avg_ff >> 4) + (count_ff >> 4);
            end
            default: state_ff <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // ************************************************************
  // pin drivers
  // ************************************************************
  wire prox_act  = (state_ff != ST_IDLE);
  wire event_act = bank2_ff[`B2_OUT_EVENT] ? (state_ff == ST_TOUCH) : prox_act;
  wire act_high  = bank0_ff[`B0_POLARITY] | bank1_ff[`B1_STREAM];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_out <= 1'b0;
      detect_oe  <= 1'b0;
      ctrl_out   <= 1'b0;
      ctrl_oe    <= 1'b0;
    end else if (clk_en) begin
      if (act_high) begin
        detect_out <= event_act;
        detect_oe  <= 1'b1;
      end else begin
        detect_out <= 1'b0;
        detect_oe  <= event_act;
      end
      ctrl_oe  <= ~ctrl_is_in;
      ctrl_out <= ctrl_is_in ? 1'b0 : (act_high ? prox_act : ~prox_act);
    end
  end

endmodule

// [bench/front_end_model.sv]
// behavioural charge-transfer front end for the detector bench
// assumes the bench sets the pulse total before each charge cycle
`timescale 1ns/10ps
module front_end_model (
  // clock
  input  wire        pclk,
  input  wire        clk_en,
  // detector side
  input  wire        charge_run,
  input  wire [15:0] pulses,
  output reg         xfer_pulse,
  output reg         ref_trip
);
  reg [16:0] n_ff;
  initial begin
    xfer_pulse = 1'b0;
    ref_trip = 1'b0;
    n_ff = 17'h0;
  end
  // pulses then trip
  // trip is raised once; the count runs past the total so it never repeats
  // frozen with the detector so that no trip is lost
  always @(posedge pclk) begin
    if (clk_en) begin
      xfer_pulse <= 1'b0;
      ref_trip <= 1'b0;
      if (!charge_run) begin
        n_ff <= 17'h0;
      end else if (n_ff < {1'b0, pulses}) begin
        xfer_pulse <= 1'b1;
        n_ff <= n_ff + 17'h1;
      end else if (n_ff == {1'b0, pulses}) begin
        ref_trip <= 1'b1;
        n_ff <= n_ff + 17'h1;
      end
    end
  end
endmodule

// [bench/touch_detector_assertions.sv]
// concurrent checks on the detector's apb, front-end and pin ports
// assumes one pclk domain; bound onto touch_detector
`timescale 1ns/10ps
module touch_detector_assertions (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  input wire        clk_en,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // front end
  input wire        xfer_pulse,
  input wire        ref_trip,
  input wire        charge_run,
  input wire [9:0]  tuning_target,
  input wire        tuning_start,
  input wire        stream_enable,
  // pins
  input wire        detect_out,
  input wire        detect_oe,
  input wire        ctrl_in,
  input wire        ctrl_out,
  input wire        ctrl_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ********************
  // properties
  // ********************
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered next cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel) && $past(penable))
    else $error("pready without access");
  err_unmapped_a: assert property (psel && penable && !pready && paddr > 12'h014 |=> pslverr)
    else $error("unmapped access not refused");
  err_only_a: assert property (pslverr |-> pready && ($past(paddr) > 12'h014 || $past(paddr[1:0]) != 2'h0))
    else $error("error on mapped access");
  run_until_trip_a: assert property (charge_run && !ref_trip |=> charge_run)
    else $error("charge cycle ended without trip");
  end_on_trip_a: assert property ($fell(charge_run) |-> $past(ref_trip))
    else $error("charge cycle end not caused by trip");
  tune_pulse_a: assert property (tuning_start |=> !tuning_start)
    else $error("tuning start longer than one cycle");
  tune_after_fall_a: assert property (tuning_start |-> !$past(ctrl_in, 1) && !$past(ctrl_in, 2))
    else $error("tuning start while control pulse still high");
  reset_quiet_a: assert property ($rose(presetn) |-> !ctrl_oe && !charge_run && !pready)
    else $error("outputs not quiet after reset");
endmodule
bind touch_detector touch_detector_assertions chk_i (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .xfer_pulse(xfer_pulse), .ref_trip(ref_trip),
  .charge_run(charge_run), .tuning_target(tuning_target), .tuning_start(tuning_start),
  .stream_enable(stream_enable), .detect_out(detect_out), .detect_oe(detect_oe),
  .ctrl_in(ctrl_in), .ctrl_out(ctrl_out), .ctrl_oe(ctrl_oe)
);

// [bench/tb_top.sv]
// self-checking bench for touch_detector with a front-end model
// assumes shortened interval, second, pulse and halt counts
`timescale 1ns/10ps
module tb_top;
  reg         pclk, presetn, clk_en, psel, penable, pwrite, ctrl_in, e;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, r, f;
  reg  [15:0] cnt;
  wire [31:0] prdata;
  wire [9:0]  tuning_target;
  wire        pready, pslverr, xfer_pulse, ref_trip, charge_run, tuning_start;
  wire        stream_enable, detect_out, detect_oe, ctrl_out, ctrl_oe;
  integer     n_fail, checked, cyc;
  touch_detector #(.INTV0_CYC(400), .SEC_CYC(100), .PULSE_MIN_CYC(20), .PULSE_MAX_CYC(40),
    .EXT_HALT_CYC(60)) dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xfer_pulse(xfer_pulse), .ref_trip(ref_trip),
    .charge_run(charge_run), .tuning_target(tuning_target), .tuning_start(tuning_start),
    .stream_enable(stream_enable), .detect_out(detect_out), .detect_oe(detect_oe),
    .ctrl_in(ctrl_in), .ctrl_out(ctrl_out), .ctrl_oe(ctrl_oe));
  front_end_model fe (.pclk(pclk), .clk_en(clk_en), .charge_run(charge_run), .pulses(cnt),
    .xfer_pulse(xfer_pulse), .ref_trip(ref_trip));
  always #12.5 pclk = ~pclk;
  // ********************
  // shared tasks
  // ********************
  task results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard: the whole run needs about 12000 cycles
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input string nm, input [11:0] a, input [31:0] x);
    apb(a, 1'b0, 32'h0);
    chk(nm, r, x);
  endtask
  task samp(input integer n);
    repeat (n) @(negedge charge_run);
    repeat (6) @(posedge pclk);
  endtask
  task pulse(input integer len, input [31:0] exp);
    integer hit;
    hit = 0;
    ctrl_in <= 1'b1;
    repeat (len) @(posedge pclk);
    ctrl_in <= 1'b0;
    repeat (8) begin
      @(posedge pclk);
      if (tuning_start === 1'b1) hit = 1;
    end
    chk("tuning start", hit, exp);
  endtask
  // ********************
  // scenarios
  // ********************
  task t_regs;
    rd("bank0 reset", 12'h000, 32'h0);
    rd("bank1 reset", 12'h004, 32'h0);
    rd("bank2 reset", 12'h008, 32'h0);
    apb(12'h000, 1'b1, 32'hFF);
    rd("bank0 bits", 12'h000, 32'hFB);
    apb(12'h004, 1'b1, 32'hFF);
    rd("bank1 bits", 12'h004, 32'hF9);
    chk("stream on", stream_enable, 32'h1);
    apb(12'h008, 1'b1, 32'hFF);
    rd("bank2 bits", 12'h008, 32'h3E);
    apb(12'h018, 1'b0, 32'h0);
    chk("unmapped data", r, 32'h0);
    chk("unmapped error", e, 32'h1);
  endtask
  task t_decode;
    integer i;
    reg [79:0] tab;
    tab = {10'h352, 10'h2BC, 10'h226, 10'h190, 10'h15E, 10'h12C, 10'h0FA, 10'h0C8};
    for (i = 0; i < 8; i = i + 1) begin
      apb(12'h008, 1'b1, i << 1);
      repeat (2) @(posedge pclk);
      chk("tuning target", tuning_target, tab[i*10 +: 10]);
    end
  endtask
  task t_pins;
    apb(12'h000, 1'b1, 32'h00);
    apb(12'h004, 1'b1, 32'h01);
    repeat (3) @(posedge pclk);
    chk("stream off", stream_enable, 32'h0);
    chk("detect released", detect_oe, 32'h0);
    chk("ctrl driven", ctrl_oe, 32'h1);
    chk("ctrl idle low mode", ctrl_out, 32'h1);
    apb(12'h000, 1'b1, 32'h02);
    repeat (3) @(posedge pclk);
    chk("ctrl idle high mode", ctrl_out, 32'h0);
  endtask
  task t_prox;
    apb(12'h008, 1'b1, 32'h00);
    samp(3);
    cnt <= 16'h0118;
    rd("count", 12'h00C, 32'h12C);
    samp(5);
    chk("detect after five", detect_out, 32'h0);
    samp(1);
    chk("detect after six", detect_out, 32'h1);
    chk("ctrl on proximity", ctrl_out, 32'h1);
    apb(12'h014, 1'b0, 32'h0);
    f = r;
    samp(1);
    cnt <= 16'h00F0;
    rd("average frozen", 12'h014, f);
    samp(2);
    cnt <= 16'h012C;
    rd("average reload", 12'h014, f - 32'h28);
    samp(1);
    chk("released", detect_out, 32'h0);
  endtask
  task t_halt;
    integer k;
    apb(12'h004, 1'b1, 32'h00);
    pulse(30, 32'h1);
    pulse(19, 32'h0);
    pulse(20, 32'h1);
    pulse(40, 32'h1);
    pulse(41, 32'h0);
    ctrl_in <= 1'b1;
    repeat (900) @(posedge pclk);
    chk("run in standby", charge_run, 32'h0);
    apb(12'h010, 1'b0, 32'h0);
    chk("standby flag", r[4], 32'h1);
    ctrl_in <= 1'b0;
    for (k = 0; k < 600 && charge_run !== 1'b1; k = k + 1) @(posedge pclk);
    chk("run resumed", charge_run, 32'h1);
  endtask
  task t_freeze;
    apb(12'h008, 1'b1, 32'h02);
    clk_en <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("frozen target", tuning_target, 32'h352);
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("thawed target", tuning_target, 32'h0FA);
  endtask
  task t_fault;
    apb(12'h000, 1'b1, 32'h00);
    apb(12'h004, 1'b1, 32'h18);
    samp(2);
    cnt <= 16'h0118;
    samp(6);
    chk("open drain driven", detect_oe, 32'h1);
    chk("open drain low", detect_out, 32'h0);
    repeat (310) @(posedge pclk);
    chk("fault released", detect_oe, 32'h0);
    samp(1);
    rd("average reseeded", 12'h014, 32'h118);
  endtask
  task t_filt;
    apb(12'h000, 1'b1, 32'h03);
    ctrl_in <= 1'b1;
    repeat (70) @(posedge pclk);
    cnt <= 16'h012C;
    samp(2);
    rd("average held", 12'h014, 32'h118);
    ctrl_in <= 1'b0;
    samp(1);
    rd("average tracks", 12'h014, 32'h119);
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ctrl_in = 1'b0;
    cnt = 16'h012C;
    n_fail = 0;
    checked = 0;
    cyc = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_decode;
    t_freeze;
    t_pins;
    t_prox;
    t_halt;
    t_fault;
    t_filt;
    results;
  end
endmodule
